// ===== include/rcpe_pkg.sv
package rcpe_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned BAUD_00 = 2_400;
    localparam int unsigned BAUD_01 = 9_600;
    localparam int unsigned BAUD_10 = 19_200;
    localparam int unsigned BAUD_11 = 28_800;
    localparam int unsigned BIT_CYCLES_00 = CLK_HZ / BAUD_00;
    localparam int unsigned BIT_CYCLES_01 = CLK_HZ / BAUD_01;
    localparam int unsigned BIT_CYCLES_10 = CLK_HZ / BAUD_10;
    localparam int unsigned BIT_CYCLES_11 = CLK_HZ / BAUD_11;
    localparam int unsigned DIV_W = 16;
    localparam int unsigned BLINK_MILLIS = 250;
    localparam int unsigned BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MILLIS;
    localparam int unsigned BLINK_W = 28;
    localparam int unsigned CODE_W = 24;
    localparam int unsigned CODE_SPACE = 16_777_216;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned PACKET_BYTES = 5;
    localparam int unsigned FRAME_BITS = 10;
    localparam int unsigned SYNC_SETTLE = 3;
    localparam logic [23:0] LFSR_SEED = 24'hACE001;
    localparam logic [23:0] LFSR_TAPS = 24'hE10000;
    typedef struct packed {
        logic [23:0] code;
        logic [7:0] mask;
    } rcpe_nv_t;
    typedef struct packed {
        logic [23:0] code;
        logic [7:0] data;
        logic [7:0] mask;
    } rcpe_packet_t;
    typedef enum logic [2:0] {
        ST_POWERUP = 3'h0,
        ST_SLEEP = 3'h1,
        ST_CREATE = 3'h2,
        ST_PERMIT = 3'h3,
        ST_SEND_LOAD = 3'h4,
        ST_SEND_DRAIN = 3'h5
    } rcpe_state_t;
endpackage

// ===== design/rcpe_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module rcpe_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_out = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // rcpe_fifo
`default_nettype wire

// ===== design/rcpe_serializer.sv
`timescale 1ns/10ps
`default_nettype none
module rcpe_serializer (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [rcpe_pkg::DIV_W-1:0] bit_cycles_in,
    input wire logic byte_valid_in,
    output logic byte_ready_out,
    input wire logic [rcpe_pkg::BYTE_W-1:0] byte_in,
    output logic busy_out,
    output logic serial_out
);
    logic [rcpe_pkg::DIV_W-1:0] div_cnt;
    logic [rcpe_pkg::FRAME_BITS-1:0] shift;
    logic [3:0] bits_left;
    logic bit_tick;

    assign busy_out = (bits_left != 4'h0);
    assign byte_ready_out = !busy_out;
    assign bit_tick = busy_out && (div_cnt == bit_cycles_in - 1'b1);

    // Bit-rate divider: one-cycle enable per bit period, restarted with each frame.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_cnt <= '0;
        end else if (!busy_out || bit_tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // Frame is start bit, eight data bits LSB first, stop bit; line idles high.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            shift <= '1;
            bits_left <= 4'h0;
            serial_out <= 1'b1;
        end else if (byte_valid_in && byte_ready_out) begin
            shift <= {1'b1, byte_in, 1'b0};
            bits_left <= 4'(rcpe_pkg::FRAME_BITS);
            serial_out <= 1'b0;
        end else if (bit_tick) begin
            bits_left <= bits_left - 4'h1;
            shift <= {1'b1, shift[rcpe_pkg::FRAME_BITS-1:1]};
            serial_out <= (bits_left == 4'h1) ? 1'b1 : shift[1];
        end
    end
endmodule // rcpe_serializer
`default_nettype wire

// ===== design/rcpe_encoder.sv
`timescale 1ns/10ps
`default_nettype none
module rcpe_encoder #(
    parameter int unsigned DIV_00 = rcpe_pkg::BIT_CYCLES_00,
    parameter int unsigned DIV_01 = rcpe_pkg::BIT_CYCLES_01,
    parameter int unsigned DIV_10 = rcpe_pkg::BIT_CYCLES_10,
    parameter int unsigned DIV_11 = rcpe_pkg::BIT_CYCLES_11,
    parameter int unsigned BLINK = rcpe_pkg::BLINK_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [rcpe_pkg::DATA_W-1:0] data_in,
    input wire logic [1:0] baud_sel_in,
    input wire logic create_addr_in,
    input wire logic send_in,
    input wire rcpe_pkg::rcpe_nv_t nv_word_in,
    output logic serial_out,
    output logic transmitter_power_ctl_out,
    output logic create_indicator_out,
    output rcpe_pkg::rcpe_nv_t nv_word_out,
    output logic nv_write_out
);
    localparam int unsigned SYNC_W = rcpe_pkg::DATA_W + 4;

    rcpe_pkg::rcpe_state_t state;
    rcpe_pkg::rcpe_state_t next_state;

    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_pins;
    logic [rcpe_pkg::DATA_W-1:0] data_s;
    logic [1:0] baud_sel_s;
    logic create_s;
    logic send_s;
    logic create_prev;
    logic create_rise;

    logic [1:0] settle_cnt;
    logic [rcpe_pkg::DIV_W-1:0] bit_cycles;
    logic [rcpe_pkg::CODE_W-1:0] lfsr;
    logic [rcpe_pkg::CODE_W-1:0] code_word;
    logic [rcpe_pkg::DATA_W-1:0] perm_mask;
    logic [rcpe_pkg::DATA_W-1:0] perm_capture;
    logic [rcpe_pkg::BLINK_W-1:0] blink_cnt;
    logic blink;
    rcpe_pkg::rcpe_nv_t nv_meta;
    rcpe_pkg::rcpe_nv_t nv_sync;
    logic nv_load;
    logic [rcpe_pkg::CODE_W-1:0] live_code;
    logic [rcpe_pkg::DATA_W-1:0] live_mask;

    rcpe_pkg::rcpe_packet_t packet;
    logic [2:0] byte_idx;
    logic start_packet;
    logic [rcpe_pkg::BYTE_W-1:0] push_byte;
    logic push_valid;
    logic push_ready;
    logic fifo_valid;
    logic fifo_ready;
    logic [rcpe_pkg::BYTE_W-1:0] fifo_byte;
    logic ser_busy;

    // data_in, baud_sel_in, create_addr_in and send_in are asynchronous to clk_in, so all of them pass two flops.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_meta <= '0;
            sync_pins <= '0;
        end else begin
            sync_meta <= {data_in, baud_sel_in, create_addr_in, send_in};
            sync_pins <= sync_meta;
        end
    end

    // The store's contents arrive from outside the clock domain as well.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            nv_meta <= '0;
            nv_sync <= '0;
        end else begin
            nv_meta <= nv_word_in;
            nv_sync <= nv_meta;
        end
    end

    assign data_s = sync_pins[SYNC_W-1:4];
    assign baud_sel_s = sync_pins[3:2];
    assign create_s = sync_pins[1];
    assign send_s = sync_pins[0];
    assign create_rise = create_s && !create_prev;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            create_prev <= 1'b0;
        end else begin
            create_prev <= create_s;
        end
    end

    // Waits for the synchronisers to fill before the straps are trusted.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            settle_cnt <= '0;
        end else if (state == rcpe_pkg::ST_POWERUP) begin
            settle_cnt <= settle_cnt + 2'h1;
        end
    end

    // The rate is taken once, at power-up, and never again.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bit_cycles <= rcpe_pkg::DIV_W'(DIV_00);
        end else if (state == rcpe_pkg::ST_POWERUP &&
                     settle_cnt == 2'(rcpe_pkg::SYNC_SETTLE)) begin
            case (baud_sel_s)
                2'h0: bit_cycles <= rcpe_pkg::DIV_W'(DIV_00);
                2'h1: bit_cycles <= rcpe_pkg::DIV_W'(DIV_01);
                2'h2: bit_cycles <= rcpe_pkg::DIV_W'(DIV_10);
                2'h3: bit_cycles <= rcpe_pkg::DIV_W'(DIV_11);
                default: bit_cycles <= rcpe_pkg::DIV_W'(DIV_00);
            endcase
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            rcpe_pkg::ST_POWERUP: begin
                if (settle_cnt == 2'(rcpe_pkg::SYNC_SETTLE)) begin
                    // Send already high goes straight to transmitting.
                    next_state = send_s ? rcpe_pkg::ST_SEND_LOAD
                                        : rcpe_pkg::ST_SLEEP;
                end
            end
            rcpe_pkg::ST_SLEEP: begin
                // Send wins when both buttons arrive together.
                if (send_s) begin
                    next_state = rcpe_pkg::ST_SEND_LOAD;
                end else if (create_rise) begin
                    next_state = rcpe_pkg::ST_CREATE;
                end
            end
            rcpe_pkg::ST_CREATE: begin
                if (!create_s) begin
                    next_state = rcpe_pkg::ST_PERMIT;
                end
            end
            rcpe_pkg::ST_PERMIT: begin
                // Only a fresh press saves; the release that led here does not.
                if (create_rise) begin
                    next_state = rcpe_pkg::ST_SLEEP;
                end
            end
            rcpe_pkg::ST_SEND_LOAD: begin
                // Create is ignored for as long as the transmitter is on.
                if (push_ready && byte_idx == 3'(rcpe_pkg::PACKET_BYTES - 1)) begin
                    next_state = rcpe_pkg::ST_SEND_DRAIN;
                end
            end
            rcpe_pkg::ST_SEND_DRAIN: begin
                // A packet in progress always completes before send is rechecked.
                if (!fifo_valid && !ser_busy) begin
                    next_state = send_s ? rcpe_pkg::ST_SEND_LOAD
                                        : rcpe_pkg::ST_SLEEP;
                end
            end
            default: next_state = rcpe_pkg::ST_SLEEP;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= rcpe_pkg::ST_POWERUP;
        end else begin
            state <= next_state;
        end
    end

    assign start_packet = (next_state == rcpe_pkg::ST_SEND_LOAD) &&
                          (state != rcpe_pkg::ST_SEND_LOAD);

    // The generator runs every cycle, so the word held at release depends on
    // how long the user held the button.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lfsr <= rcpe_pkg::LFSR_SEED;
        end else begin
            lfsr <= {1'b0, lfsr[rcpe_pkg::CODE_W-1:1]} ^
                    (lfsr[0] ? rcpe_pkg::LFSR_TAPS : '0);
        end
    end

    // Stored identity, restored from the nonvolatile store at power-up.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            code_word <= '0;
        end else if (state == rcpe_pkg::ST_POWERUP &&
                     settle_cnt == 2'(rcpe_pkg::SYNC_SETTLE)) begin
            code_word <= nv_sync.code;
        end else if (state == rcpe_pkg::ST_CREATE && !create_s) begin
            code_word <= lfsr;
        end
    end

    // Permission capture collects every data input seen active.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            perm_capture <= '0;
        end else if (state == rcpe_pkg::ST_CREATE) begin
            perm_capture <= '0;
        end else if (state == rcpe_pkg::ST_PERMIT) begin
            perm_capture <= perm_capture | data_s;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            perm_mask <= '0;
        end else if (state == rcpe_pkg::ST_POWERUP &&
                     settle_cnt == 2'(rcpe_pkg::SYNC_SETTLE)) begin
            perm_mask <= nv_sync.mask;
        end else if (state == rcpe_pkg::ST_PERMIT && create_rise) begin
            perm_mask <= perm_capture;
        end
    end

    // One write of code and mask when create mode completes.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            nv_word_out <= '0;
            nv_write_out <= 1'b0;
        end else begin
            nv_write_out <= 1'b0;
            if (state == rcpe_pkg::ST_PERMIT && create_rise) begin
                nv_word_out <= '{code: code_word, mask: perm_capture};
                nv_write_out <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            blink_cnt <= '0;
            blink <= 1'b0;
        end else if (state != rcpe_pkg::ST_PERMIT) begin
            blink_cnt <= '0;
            blink <= 1'b1;
        end else if (blink_cnt == rcpe_pkg::BLINK_W'(BLINK - 1)) begin
            blink_cnt <= '0;
            blink <= !blink;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            create_indicator_out <= 1'b0;
        end else begin
            case (next_state)
                rcpe_pkg::ST_CREATE: create_indicator_out <= 1'b1;
                rcpe_pkg::ST_PERMIT: create_indicator_out <= blink;
                default: create_indicator_out <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            transmitter_power_ctl_out <= 1'b0;
        end else begin
            transmitter_power_ctl_out <= (next_state == rcpe_pkg::ST_SEND_LOAD) ||
                                         (next_state == rcpe_pkg::ST_SEND_DRAIN);
        end
    end

    // A packet started at the power-up decision would otherwise see the
    // stored words before they are loaded, so it takes them from the store.
    assign nv_load = (state == rcpe_pkg::ST_POWERUP) &&
                     (settle_cnt == 2'(rcpe_pkg::SYNC_SETTLE));
    assign live_code = nv_load ? nv_sync.code : code_word;
    assign live_mask = nv_load ? nv_sync.mask : perm_mask;

    // Data is sampled fresh for each packet and gated by the permission mask,
    // so a receiver never sees an unauthorised input active.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            packet <= '0;
        end else if (start_packet) begin
            packet <= '{code: live_code,
                        data: data_s & live_mask,
                        mask: live_mask};
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            byte_idx <= '0;
        end else if (start_packet) begin
            byte_idx <= '0;
        end else if (state == rcpe_pkg::ST_SEND_LOAD && push_ready) begin
            byte_idx <= byte_idx + 3'h1;
        end
    end

    // Byte order on the line: code high, middle, low, data, mask.
    always_comb begin
        case (byte_idx)
            3'h0: push_byte = packet.code[23:16];
            3'h1: push_byte = packet.code[15:8];
            3'h2: push_byte = packet.code[7:0];
            3'h3: push_byte = packet.data;
            3'h4: push_byte = packet.mask;
            default: push_byte = 8'hFF;
        endcase
    end

    assign push_valid = (state == rcpe_pkg::ST_SEND_LOAD);

    rcpe_fifo #(
        .WIDTH(rcpe_pkg::BYTE_W),
        .DEPTH(rcpe_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_valid_in(push_valid),
        .in_ready_out(push_ready),
        .in_data_in(push_byte),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_ready),
        .out_data_out(fifo_byte)
    );

    rcpe_serializer u_ser (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .bit_cycles_in(bit_cycles),
        .byte_valid_in(fifo_valid),
        .byte_ready_out(fifo_ready),
        .byte_in(fifo_byte),
        .busy_out(ser_busy),
        .serial_out(serial_out)
    );
endmodule // rcpe_encoder
`default_nettype wire

// ===== tb/rcpe_encoder_properties.sv
`timescale 1ns/10ps
`default_nettype none
module rcpe_encoder_properties (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic send_in,
    input wire logic create_addr_in,
    input wire logic serial_out,
    input wire logic transmitter_power_ctl_out,
    input wire logic create_indicator_out,
    input wire logic nv_write_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    property p_idle_high;
        !transmitter_power_ctl_out |-> serial_out;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("serial line low while transmitter off");
    property p_send_power;
        $rose(send_in) && !transmitter_power_ctl_out && !create_indicator_out
            |-> ##[1:8] transmitter_power_ctl_out;
    endproperty
    a_send_power: assert property (p_send_power)
        else $error("transmitter control did not follow send");
    property p_create_ind;
        $rose(create_addr_in) && !transmitter_power_ctl_out
            |-> ##[1:6] (create_indicator_out || nv_write_out);
    endproperty
    a_create_ind: assert property (p_create_ind)
        else $error("create press had no effect");
    property p_ind_off;
        nv_write_out |-> ##[0:2] !create_indicator_out;
    endproperty
    a_ind_off: assert property (p_ind_off)
        else $error("indicator still on after save");
    property p_nv_pulse;
        nv_write_out |=> !nv_write_out;
    endproperty
    a_nv_pulse: assert property (p_nv_pulse)
        else $error("store write longer than one cycle");
    property p_nv_cause;
        nv_write_out |-> create_addr_in && !transmitter_power_ctl_out;
    endproperty
    a_nv_cause: assert property (p_nv_cause)
        else $error("store write without create press");
    property p_exclusive;
        transmitter_power_ctl_out |-> !create_indicator_out;
    endproperty
    a_exclusive: assert property (p_exclusive)
        else $error("create and send active together");
    property p_start_bit;
        $rose(transmitter_power_ctl_out) |-> ##[0:8] !serial_out;
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("no start bit after transmitter on");
    property p_hold_frame;
        transmitter_power_ctl_out && !serial_out |=> transmitter_power_ctl_out;
    endproperty
    a_hold_frame: assert property (p_hold_frame)
        else $error("transmitter off inside a frame");
    property p_power_off;
        $fell(transmitter_power_ctl_out) |-> !send_in && !$past(send_in, 4);
    endproperty
    a_power_off: assert property (p_power_off)
        else $error("transmitter off while send high");
endmodule // rcpe_encoder_properties
bind rcpe_encoder rcpe_encoder_properties i_rcpe_encoder_properties (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .send_in(send_in),
    .create_addr_in(create_addr_in),
    .serial_out(serial_out),
    .transmitter_power_ctl_out(transmitter_power_ctl_out),
    .create_indicator_out(create_indicator_out),
    .nv_write_out(nv_write_out)
);
`default_nettype wire

// ===== tb/rcpe_tx_model.sv
`timescale 1ns/10ps
`default_nettype none
module rcpe_tx_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic serial_in,
    input wire logic power_in,
    input wire logic [15:0] bit_cycles_in,
    output logic [7:0] byte_out,
    output logic strobe_out,
    output logic frame_err_out
);
    initial begin
        byte_out = 8'h00;
        strobe_out = 1'b0;
        frame_err_out = 1'b0;
        forever begin
            @(posedge clk_in);
            strobe_out <= 1'b0;
            // A powered-down transmitter ignores the data line.
            if (!rst_in && power_in && !serial_in) begin
                repeat (bit_cycles_in / 2) @(posedge clk_in);
                if (serial_in) frame_err_out <= 1'b1;
                for (int i = 0; i < 8; i++) begin
                    repeat (bit_cycles_in) @(posedge clk_in);
                    byte_out[i] <= serial_in;
                end
                repeat (bit_cycles_in) @(posedge clk_in);
                if (!serial_in) frame_err_out <= 1'b1;
                strobe_out <= 1'b1;
            end
        end
    end
endmodule // rcpe_tx_model
`default_nettype wire

// ===== tb/remote_control_packet_encoder_bench.sv
`timescale 1ns/10ps
`default_nettype none
module remote_control_packet_encoder_bench;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] data_in = 8'h00;
    logic [1:0] baud_sel_in = 2'h0;
    logic create_addr_in = 1'b0;
    logic send_in = 1'b0;
    rcpe_pkg::rcpe_nv_t nv_word_in = '0;
    logic serial_out;
    logic power;
    logic ind;
    rcpe_pkg::rcpe_nv_t nv_word_out;
    logic nv_write_out;
    logic [15:0] bit_cycles = 16'h0008;
    logic [7:0] rx_byte;
    logic rx_strobe;
    logic rx_err;
    logic [7:0] rxq [$];
    logic [23:0] code_a;
    logic [23:0] code_b;
    int errors = 0;
    int check_count = 0;

    rcpe_encoder #(.DIV_00(8), .DIV_01(10), .DIV_10(12), .DIV_11(14), .BLINK(4)) i_rcpe_encoder (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .data_in(data_in),
        .baud_sel_in(baud_sel_in),
        .create_addr_in(create_addr_in),
        .send_in(send_in),
        .nv_word_in(nv_word_in),
        .serial_out(serial_out),
        .transmitter_power_ctl_out(power),
        .create_indicator_out(ind),
        .nv_word_out(nv_word_out),
        .nv_write_out(nv_write_out)
    );
    rcpe_tx_model i_rcpe_tx_model (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .serial_in(serial_out),
        .power_in(power),
        .bit_cycles_in(bit_cycles),
        .byte_out(rx_byte),
        .strobe_out(rx_strobe),
        .frame_err_out(rx_err)
    );

    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (rx_strobe) rxq.push_back(rx_byte);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic wait_bytes(input int n);
        int k;
        k = 0;
        while (rxq.size() < n && k < 4000) begin
            cyc(1);
            k++;
        end
        check(32'(k < 4000), 32'h1);
    endtask
    task automatic wait_power(input logic lvl, input int lim);
        int k;
        k = 0;
        while (power !== lvl && k < lim) begin
            cyc(1);
            k++;
        end
    endtask
    task automatic do_reset(input logic s, input logic [1:0] b, input logic [7:0] d);
        @(negedge clk_in);
        rst_in = 1'b1;
        send_in = s;
        baud_sel_in = b;
        nv_word_in = rcpe_pkg::rcpe_nv_t'({24'h5A3C96, 8'h0F});
        data_in = d;
        bit_cycles = 16'(8 + 2 * b);
        rxq.delete();
        cyc(16);
        rst_in = 1'b0;
    endtask
    task automatic expect_packet(input logic [23:0] code, input logic [7:0] m, input logic [7:0] d);
        logic [7:0] exp [5];
        exp = '{code[23:16], code[15:8], code[7:0], d & m, m};
        wait_bytes(5);
        for (int i = 0; i < 5; i++) begin
            check(32'(rxq.pop_front()), 32'(exp[i]));
        end
    endtask
    task automatic t_powerup();
        cyc(20);
        check(32'(power), 32'h0);
        check(32'(serial_out), 32'h1);
        check(32'(ind), 32'h0);
    endtask
    task automatic t_create(input logic [7:0] p1, input logic [7:0] p2, input int hold,
                            output logic [23:0] code);
        int n;
        int k;
        logic prev;
        create_addr_in = 1'b1;
        cyc(8);
        check(32'(ind), 32'h1);
        cyc(hold);
        check(32'(ind), 32'h1);
        create_addr_in = 1'b0;
        cyc(10);
        n = 0;
        prev = ind;
        repeat (32) begin
            cyc(1);
            if (ind !== prev) n++;
            prev = ind;
        end
        check(32'(n), 32'h8);
        data_in = p1;
        cyc(6);
        data_in = p2;
        cyc(6);
        data_in = 8'h00;
        cyc(4);
        create_addr_in = 1'b1;
        k = 0;
        while (nv_write_out !== 1'b1 && k < 10) begin
            cyc(1);
            k++;
        end
        check(32'(nv_write_out), 32'h1);
        check(32'(nv_word_out.mask), 32'(p1 | p2));
        code = nv_word_out.code;
        cyc(6);
        check(32'(ind), 32'h0);
        check(32'(power), 32'h0);
        create_addr_in = 1'b0;
        cyc(4);
    endtask
    task automatic run_send(input logic [23:0] code, input logic [7:0] m, input logic [7:0] d1,
                            input logic [7:0] d2, input logic raise);
        data_in = d1;
        if (raise) send_in = 1'b1;
        wait_power(1'b1, 12);
        check(32'(power), 32'h1);
        expect_packet(code, m, d1);
        data_in = d2;
        wait_bytes(2);
        send_in = 1'b0;
        expect_packet(code, m, d2);
        wait_power(1'b0, 40);
        check(32'(power), 32'h0);
        cyc(300);
        check(32'(rxq.size()), 32'h0);
        check(32'(rx_err), 32'h0);
    endtask

    initial begin
        do_reset(1'b0, 2'h0, 8'h00);
        t_powerup();
        t_create(8'h05, 8'h30, 20, code_a);
        t_create(8'h81, 8'h00, 27, code_b);
        check(32'(code_a != code_b), 32'h1);
        run_send(code_b, 8'h81, 8'hFF, 8'h0F, 1'b1);
        for (int b = 1; b < 4; b++) begin
            do_reset(1'b1, 2'(b), 8'hF3);
            run_send(24'h5A3C96, 8'h0F, 8'hF3, 8'h3C, 1'b0);
            baud_sel_in = ~2'(b);
            run_send(24'h5A3C96, 8'h0F, 8'h0C, 8'h81, 1'b1);
        end
        finish_test();
    end
    initial begin
        #400000;
        errors++;
        finish_test();
    end
endmodule // remote_control_packet_encoder_bench
`default_nettype wire
